// ==== pkg/serr_map.vh ====
/*
 * Register map, field positions, reset values and event codes of the
 * bridge system-error reporting block.
 * Assumes registers are reached by configuration dword accesses with
 * byte enables, as decoded by the bridge's configuration target.
 */
// Summary of operation
// - no system error unless global enable set
// - enabled, unmasked condition raises system error
// - reset: disables zero, global reporting off
// - system error sets secondary-status signalled flag
// - enables cover downstream and upstream transfers
// - posted write parity error reports, status bit1
// - posted write retry timeout reports, status bit2
// - posted write target abort reports, status bit3
// - posted write master abort reports, status bit4
// - delayed write retry timeout reports, status bit5
// - delayed read retry timeout reports, status bit6
// - status bits clear on write one only
// - forward secondary error with global and forwarding enable
// - forwarded data parity passes through unchanged
// - parity response enables address-parity and target-abort reporting
`ifndef SERR_MAP_VH
`define SERR_MAP_VH

// ----------------------------------------------------------------
// configuration offsets (byte addresses)
// ----------------------------------------------------------------
`define OFF_COMMAND_CONTROL   8'h04
`define OFF_SEC_BUS_STATUS    8'h1E
`define OFF_BRIDGE_CONTROL    8'h3E
`define OFF_EVENT_DISABLE     8'h64
`define OFF_EVENT_STATUS      8'h6A

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CMD_PARITY_RESP_BIT   6
`define CMD_SERR_ENABLE_BIT   8
`define SEC_SIGNALLED_BIT     14
`define BCTL_SERR_FWD_BIT     1

// event bit positions, shared by disable and status registers
`define EV_PW_PARITY          1
`define EV_PW_TIMEOUT         2
`define EV_PW_TABORT          3
`define EV_PW_MABORT          4
`define EV_DW_TIMEOUT         5
`define EV_DR_TIMEOUT         6
`define EV_MASK               8'h7E

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_COMMAND_CONTROL   16'h0000
`define RST_BRIDGE_CONTROL    16'h0000
`define RST_EVENT_DISABLE     8'h00
`define RST_EVENT_STATUS      8'h00

`endif

// ==== hw/serr_event_gate.v ====
/*
 * Qualifies the six posted and delayed transaction failures against the
 * per-condition disable bits and collects them into one event vector.
 * Assumes event strobes are one-clock pulses on clk, from either
 * forwarding direction.
 */
`timescale 1ns/1ns
`include "serr_map.vh"

module serr_event_gate (
    clk,
    sys_rst,
    down_events,
    up_events,
    disable_bits,
    raw_events,
    gated_events
);
    input  wire       clk;
    input  wire       sys_rst;
    input  wire [7:0] down_events;
    input  wire [7:0] up_events;
    input  wire [7:0] disable_bits;
    output wire [7:0] raw_events;
    output wire [7:0] gated_events;

    // ------------------------------------------------------------
    // merge directions and mask
    // ------------------------------------------------------------
    // the same enables serve both directions; unused bits are masked off
    assign raw_events   = (down_events | up_events) & `EV_MASK;
    assign gated_events = raw_events & ~disable_bits;

endmodule // serr_event_gate

// ==== hw/serr_pulse_out.v ====
/*
 * Drives the primary system error pin as an open-drain output: one clock
 * of low drive per reported event, released otherwise.
 * Assumes an external pull-up returns the wire high.
 */
`timescale 1ns/1ns

module serr_pulse_out (
    clk,
    sys_rst,
    fire,
    pin_o,
    pin_oe_n
);
    input  wire clk;
    input  wire sys_rst;
    input  wire fire;
    output reg  pin_o;
    output reg  pin_oe_n;

    // ------------------------------------------------------------
    // open-drain pulse
    // ------------------------------------------------------------
    // output value is always low; only the enable moves
    always @(posedge clk) begin
        if (sys_rst) begin
            pin_o    <= 1'b0;
            pin_oe_n <= 1'b1;
        end else begin
            pin_o    <= 1'b0;
            pin_oe_n <= ~fire;
        end
    end

endmodule // serr_pulse_out

// ==== hw/serr_report.v ====
/*
 * System-error reporting for a bridge: configuration registers for the
 * command, secondary status, bridge control, event disable and event
 * status fields that concern system errors, event capture and the
 * primary system error output.
 * Assumes configuration accesses arrive as one-clock strobes from the
 * bridge's configuration target on clk, and that failure strobes come
 * from the forwarding engines on the same clock. The secondary error
 * pin and parity pins are asynchronous and are synchronised here.
 */
`timescale 1ns/1ns
`include "serr_map.vh"

module serr_report (
    clk,
    sys_rst,
    cfg_wr,
    cfg_rd,
    cfg_addr,
    cfg_be,
    cfg_wdata,
    cfg_rdata,
    cfg_rvalid,
    down_events,
    up_events,
    addr_parity_err,
    tabort_seen,
    sec_serr_n,
    par_in_pri,
    par_in_sec,
    par_out_sec,
    par_out_pri,
    primary_system_error_out_o,
    primary_system_error_out_oe_n,
    serr_enable,
    parity_resp
);
    input  wire        clk;
    input  wire        sys_rst;
    input  wire        cfg_wr;
    input  wire        cfg_rd;
    input  wire [7:0]  cfg_addr;
    input  wire [3:0]  cfg_be;
    input  wire [31:0] cfg_wdata;
    output reg  [31:0] cfg_rdata;
    output reg         cfg_rvalid;
    input  wire [7:0]  down_events;
    input  wire [7:0]  up_events;
    input  wire        addr_parity_err;
    input  wire        tabort_seen;
    input  wire        sec_serr_n;
    input  wire        par_in_pri;
    input  wire        par_in_sec;
    output reg         par_out_sec;
    output reg         par_out_pri;
    output wire        primary_system_error_out_o;
    output wire        primary_system_error_out_oe_n;
    output reg         serr_enable;
    output reg         parity_resp;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg  [15:0] command_control_r;
    reg  [15:0] bridge_control_r;
    reg  [7:0]  error_event_disable_r;
    reg  [7:0]  error_event_status_r;
    reg         signalled_r;
    reg  [1:0]  sec_serr_sync_r;
    reg         sec_serr_prev_r;
    reg  [1:0]  par_pri_sync_r;
    reg  [1:0]  par_sec_sync_r;
    reg         fire_r;
    reg  [15:0] command_nxt;
    reg  [15:0] bridge_nxt;
    reg  [7:0]  disable_nxt;
    reg  [7:0]  status_clr;

    wire [7:0]  raw_events;
    wire [7:0]  gated_events;
    wire        glob_en;
    wire        sec_serr_edge;
    wire        fwd_req;
    wire        par_req;
    wire        any_req;
    wire        status_wr;
    wire        sec_wr;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // merge a 16-bit half of a dword write under its two byte enables
    function [15:0] merge16;
        input [15:0] old_v;
        input [15:0] new_v;
        input [1:0]  be;
        begin
            merge16[7:0]  = be[0] ? new_v[7:0]  : old_v[7:0];
            merge16[15:8] = be[1] ? new_v[15:8] : old_v[15:8];
        end
    endfunction

    // dword address of a byte offset
    function [5:0] dw;
        input [7:0] off;
        begin
            dw = off[7:2];
        end
    endfunction

    wire        hit_cmd = (cfg_addr[7:2] == dw(`OFF_COMMAND_CONTROL));
    wire        hit_sec = (cfg_addr[7:2] == dw(`OFF_SEC_BUS_STATUS));
    wire        hit_bct = (cfg_addr[7:2] == dw(`OFF_BRIDGE_CONTROL));
    wire        hit_dis = (cfg_addr[7:2] == dw(`OFF_EVENT_DISABLE));
    wire        hit_sts = (cfg_addr[7:2] == dw(`OFF_EVENT_STATUS));

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    serr_event_gate u_gate (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .down_events  (down_events),
        .up_events    (up_events),
        .disable_bits (error_event_disable_r),
        .raw_events   (raw_events),
        .gated_events (gated_events)
    );

    serr_pulse_out u_pin (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .fire     (fire_r),
        .pin_o    (primary_system_error_out_o),
        .pin_oe_n (primary_system_error_out_oe_n)
    );

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            sec_serr_sync_r <= 2'b11;
            sec_serr_prev_r <= 1'b1;
            par_pri_sync_r  <= 2'b00;
            par_sec_sync_r  <= 2'b00;
        end else begin
            sec_serr_sync_r <= {sec_serr_sync_r[0], sec_serr_n};
            sec_serr_prev_r <= sec_serr_sync_r[1];
            par_pri_sync_r  <= {par_pri_sync_r[0], par_in_pri};
            par_sec_sync_r  <= {par_sec_sync_r[0], par_in_sec};
        end
    end

    // a secondary assertion is one event per falling edge, so a held-low
    // pin does not flood the primary bus
    assign sec_serr_edge = sec_serr_prev_r & ~sec_serr_sync_r[1];

    // ------------------------------------------------------------
    // reporting decision
    // ------------------------------------------------------------
    assign glob_en = command_control_r[`CMD_SERR_ENABLE_BIT];
    assign fwd_req = sec_serr_edge & bridge_control_r[`BCTL_SERR_FWD_BIT];
    assign par_req = command_control_r[`CMD_PARITY_RESP_BIT]
                     & (addr_parity_err | tabort_seen);
    assign any_req = glob_en & ((|gated_events) | fwd_req | par_req);

    assign status_wr = cfg_wr & hit_sts & cfg_be[2];
    assign sec_wr    = cfg_wr & hit_sec & cfg_be[3];

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always @* begin
        command_nxt = command_control_r;
        bridge_nxt  = bridge_control_r;
        disable_nxt = error_event_disable_r;
        status_clr  = 8'h00;
        if (cfg_wr && hit_cmd)
            command_nxt = merge16(command_control_r, cfg_wdata[15:0], cfg_be[1:0]);
        if (cfg_wr && hit_bct)
            bridge_nxt = merge16(bridge_control_r, cfg_wdata[31:16], cfg_be[3:2]);
        if (cfg_wr && hit_dis && cfg_be[0])
            disable_nxt = cfg_wdata[7:0] & `EV_MASK;
        if (status_wr)
            status_clr = cfg_wdata[23:16] & `EV_MASK;
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            command_control_r     <= `RST_COMMAND_CONTROL;
            bridge_control_r      <= `RST_BRIDGE_CONTROL;
            error_event_disable_r <= `RST_EVENT_DISABLE;
            error_event_status_r  <= `RST_EVENT_STATUS;
            signalled_r           <= 1'b0;
            fire_r                <= 1'b0;
            serr_enable           <= 1'b0;
            parity_resp           <= 1'b0;
        end else begin
            command_control_r     <= command_nxt;
            bridge_control_r      <= bridge_nxt;
            error_event_disable_r <= disable_nxt;
            // a new event in the clearing cycle wins over the clear
            error_event_status_r  <= (error_event_status_r & ~status_clr)
                                     | (glob_en ? gated_events : 8'h00);
            if (any_req)
                signalled_r <= 1'b1;
            else if (sec_wr && cfg_wdata[16 + `SEC_SIGNALLED_BIT])
                signalled_r <= 1'b0;
            fire_r                <= any_req;
            serr_enable           <= command_nxt[`CMD_SERR_ENABLE_BIT];
            parity_resp           <= command_nxt[`CMD_PARITY_RESP_BIT];
        end
    end

    // ------------------------------------------------------------
    // parity pass-through
    // ------------------------------------------------------------
    // parity is carried, never regenerated, so a bad word stays bad
    always @(posedge clk) begin
        if (sys_rst) begin
            par_out_sec <= 1'b0;
            par_out_pri <= 1'b0;
        end else begin
            par_out_sec <= par_pri_sync_r[1];
            par_out_pri <= par_sec_sync_r[1];
        end
    end

    // ------------------------------------------------------------
    // reads
    // ------------------------------------------------------------
    // unmapped dwords read as zero; answer comes one clock after the strobe
    always @(posedge clk) begin
        if (sys_rst) begin
            cfg_rdata  <= 32'h00000000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd) begin
                if (hit_cmd)
                    cfg_rdata <= {16'h0000, command_control_r};
                else if (hit_sec)
                    cfg_rdata <= {1'b0, signalled_r, 30'h00000000};
                else if (hit_bct)
                    cfg_rdata <= {bridge_control_r, 16'h0000};
                else if (hit_dis)
                    cfg_rdata <= {24'h000000, error_event_disable_r};
                else if (hit_sts)
                    cfg_rdata <= {8'h00, error_event_status_r, 16'h0000};
                else
                    cfg_rdata <= 32'h00000000;
            end
        end
    end

endmodule // serr_report

// ==== verif/serr_bus_agents.sv ====
/* far side of the error pins: pull-up on the primary error wire and a
   secondary agent; assumes requests arrive away from the rising edge */
`timescale 1ns/1ns
module serr_bus_agents (
    input  wire clk,
    input  wire pin_o,
    input  wire pin_oe_n,
    input  wire sec_req,
    output wire serr_wire,
    output reg  sec_serr_n
);
    // a released open-drain wire is pulled back high, never left floating
    assign serr_wire = pin_oe_n ? 1'b1 : pin_o;
    initial sec_serr_n = 1'b1;
    // secondary agent pulls its line low for one clock per request
    always @(posedge clk) begin
        sec_serr_n <= !sec_req;
    end
endmodule // serr_bus_agents

// ==== verif/serr_report_checker.sv ====
/* port-level timing checks of the system-error reporting block;
   assumes one clock and a synchronous active-high reset */
`timescale 1ns/1ns
module serr_report_checker (
    input wire        clk,
    input wire        sys_rst,
    input wire        cfg_wr,
    input wire        cfg_rd,
    input wire [7:0]  cfg_addr,
    input wire [3:0]  cfg_be,
    input wire [31:0] cfg_wdata,
    input wire [31:0] cfg_rdata,
    input wire        cfg_rvalid,
    input wire [7:0]  down_events,
    input wire [7:0]  up_events,
    input wire        addr_parity_err,
    input wire        tabort_seen,
    input wire        sec_serr_n,
    input wire        par_in_pri,
    input wire        par_in_sec,
    input wire        par_out_sec,
    input wire        par_out_pri,
    input wire        primary_system_error_out_o,
    input wire        primary_system_error_out_oe_n,
    input wire        serr_enable,
    input wire        parity_resp
);
    reg  [7:0] dis_r;
    reg        fwd_r;
    reg  [2:0] rc_r;
    wire       fire_n = primary_system_error_out_oe_n;
    wire [7:0] ev     = (down_events | up_events) & 8'h7E;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // shadow copies of the disable and forwarding fields
    always @(posedge clk) begin
        if (sys_rst) begin
            dis_r <= 8'h00;
            fwd_r <= 1'b0;
            rc_r  <= 3'h0;
        end else begin
            if (rc_r != 3'h7)
                rc_r <= rc_r + 3'h1;
            if (cfg_wr && cfg_addr[7:2] == 6'h19 && cfg_be[0])
                dis_r <= cfg_wdata[7:0];
            if (cfg_wr && cfg_addr[7:2] == 6'h0F && cfg_be[2])
                fwd_r <= cfg_wdata[17];
        end
    end
    property p_off;
        !serr_enable [*6] |-> fire_n;
    endproperty
    a_off: assert property (p_off) else $error("error output while off");
    property p_fire;
        serr_enable && $past(serr_enable) && (ev & ~dis_r) != 8'h00 |-> ##2 !fire_n;
    endproperty
    a_fire: assert property (p_fire) else $error("event not reported");
    property p_drive_low;
        !primary_system_error_out_o;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("pin driven high");
    property p_rvalid;
        1'b1 |=> cfg_rvalid == $past(cfg_rd);
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer misplaced");
    property p_rhold;
        !cfg_rvalid |-> $stable(cfg_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data moved");
    property p_fwd;
        $fell(sec_serr_n) && serr_enable && fwd_r |-> ##[2:6] !fire_n;
    endproperty
    a_fwd: assert property (p_fwd) else $error("secondary error lost");
    property p_par;
        rc_r == 3'h7 |-> par_out_sec == $past(par_in_pri, 3) && par_out_pri == $past(par_in_sec, 3);
    endproperty
    a_par: assert property (p_par) else $error("parity not passed");
    property p_addr_par;
        parity_resp && serr_enable && (addr_parity_err || tabort_seen) |-> ##[1:3] !fire_n;
    endproperty
    a_addr_par: assert property (p_addr_par) else $error("parity event lost");
    c_fire: cover property (!fire_n);
    c_fwd: cover property ($fell(sec_serr_n) && fwd_r);
    c_read: cover property (cfg_rvalid);
endmodule // serr_report_checker

bind serr_report serr_report_checker chk (.*);

// ==== verif/serr_report_bench.sv ====
/* self-checking bench of the system-error reporting block; assumes the
   far-side model resolves the error wire and drives the secondary line */
`timescale 1ns/1ns
module serr_report_bench;
    reg         clk, sys_rst, cfg_wr, cfg_rd, ap, ta, pi_p, pi_s, sq;
    reg  [7:0]  addr, dn, up;
    reg  [3:0]  be;
    reg  [31:0] wd, got;
    wire [31:0] rd;
    wire        rv, po_s, po_p, pin_o, pin_oe_n, lvl, sec_n, en, pr;
    integer     n_fail, tests_run, i, lows;
    serr_report dut (.clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wd), .cfg_rdata(rd), .cfg_rvalid(rv),
        .down_events(dn), .up_events(up), .addr_parity_err(ap), .tabort_seen(ta),
        .sec_serr_n(sec_n), .par_in_pri(pi_p), .par_in_sec(pi_s), .par_out_sec(po_s),
        .par_out_pri(po_p), .primary_system_error_out_o(pin_o),
        .primary_system_error_out_oe_n(pin_oe_n), .serr_enable(en), .parity_resp(pr));
    serr_bus_agents agents (.clk(clk), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .sec_req(sq),
        .serr_wire(lvl), .sec_serr_n(sec_n));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task chk(input [31:0] g, input [31:0] e);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task cfg_w(input [7:0] a, input [3:0] b, input [31:0] d);
        begin
            @(negedge clk);
            addr = a;
            be = b;
            wd = d;
            cfg_wr = 1'b1;
            @(negedge clk);
            cfg_wr = 1'b0;
        end
    endtask
    task rd_chk(input [7:0] a, input [31:0] m, input [31:0] e);
        begin
            @(negedge clk);
            addr = a;
            cfg_rd = 1'b1;
            @(negedge clk);
            cfg_rd = 1'b0;
            chk({31'h0, rv}, 32'h1);
            chk(rd & m, e);
        end
    endtask
    // strobes held k cycles, then the wire is watched for n cycles
    task kick(input [7:0] d, input [7:0] u, input a, input t, input s, input integer k,
              input integer n);
        begin
            @(negedge clk);
            dn = d;
            up = u;
            ap = a;
            ta = t;
            sq = s;
            repeat (k) @(negedge clk);
            {dn, up, ap, ta, sq} = 19'h0;
            lows = 0;
            for (i = 0; i < n; i = i + 1) begin
                if (lvl !== 1'b1)
                    lows = lows + 1;
                @(negedge clk);
            end
        end
    endtask
    task t_reset;
        begin
            rd_chk(8'h04, 32'hFFFFFFFF, 32'h0);
            rd_chk(8'h1C, 32'hFFFFFFFF, 32'h0);
            rd_chk(8'h3C, 32'hFFFFFFFF, 32'h0);
            rd_chk(8'h64, 32'hFFFFFFFF, 32'h0);
            rd_chk(8'h68, 32'hFFFFFFFF, 32'h0);
            rd_chk(8'h80, 32'hFFFFFFFF, 32'h0);
            kick(8'h02, 8'h00, 1'b0, 1'b0, 1'b0, 1, 6);
            chk(lows, 0);
            rd_chk(8'h68, 32'hFFFFFFFF, 32'h0);
            $display("reset and off test done");
        end
    endtask
    task t_events;
        integer b;
        begin
            cfg_w(8'h04, 4'h3, 32'h0100);
            chk({en, pr}, 2'b10);
            for (b = 1; b < 7; b = b + 1) begin
                kick(b[0] ? 8'h01 << b : 8'h00, b[0] ? 8'h00 : 8'h01 << b, 0, 0, 0, 1, 6);
                chk(lows, 1);
                rd_chk(8'h68, 32'h00FF0000, 32'h1 << (16 + b));
                rd_chk(8'h1C, 32'h40000000, 32'h40000000);
                cfg_w(8'h68, 4'h4, 32'h0);
                rd_chk(8'h68, 32'h00FF0000, 32'h1 << (16 + b));
                cfg_w(8'h68, 4'h4, 32'h1 << (16 + b));
                rd_chk(8'h68, 32'h00FF0000, 32'h0);
            end
            cfg_w(8'h1C, 4'h8, 32'h0);
            rd_chk(8'h1C, 32'h40000000, 32'h40000000);
            cfg_w(8'h1C, 4'h8, 32'h40000000);
            rd_chk(8'h1C, 32'h40000000, 32'h0);
            $display("event test done");
        end
    endtask
    task t_mask;
        begin
            cfg_w(8'h64, 4'h1, 32'hFF);
            rd_chk(8'h64, 32'hFF, 32'h7E);
            kick(8'h7E, 8'h7E, 1'b0, 1'b0, 1'b0, 1, 6);
            chk(lows, 0);
            rd_chk(8'h68, 32'h00FF0000, 32'h0);
            cfg_w(8'h64, 4'h1, 32'h0);
            kick(8'h08, 8'h00, 1'b0, 1'b0, 1'b0, 2, 8);
            chk(lows, 2);
            cfg_w(8'h68, 4'h4, 32'h00FF0000);
            $display("mask test done");
        end
    endtask
    task t_fwd;
        begin
            kick(8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 1, 10);
            chk(lows, 0);
            cfg_w(8'h3C, 4'h4, 32'h00020000);
            kick(8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 1, 10);
            chk(lows, 1);
            {pi_p, pi_s} = 2'b10;
            repeat (5) @(negedge clk);
            chk({po_s, po_p}, 2'b10);
            {pi_p, pi_s} = 2'b01;
            repeat (5) @(negedge clk);
            chk({po_s, po_p}, 2'b01);
            kick(8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 1, 6);
            chk(lows, 0);
            cfg_w(8'h04, 4'h3, 32'h0140);
            chk({en, pr}, 2'b11);
            kick(8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 1, 6);
            chk(lows, 1);
            kick(8'h00, 8'h00, 1'b0, 1'b1, 1'b0, 1, 6);
            chk(lows, 1);
            $display("forward and parity test done");
        end
    endtask
    task test_done;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        #20000;
        n_fail = n_fail + 1;
        test_done;
    end
    initial begin
        {n_fail, tests_run} = 0;
        {cfg_wr, cfg_rd, ap, ta, pi_p, pi_s, sq, addr, dn, up, be, wd} = 0;
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        t_reset;
        t_events;
        t_mask;
        t_fwd;
        test_done;
    end
endmodule // serr_report_bench
